// File: rtl/zap_pkg.sv
package zap_pkg;
	// Special-purpose register number of the zone override register.
	localparam logic [9:0] ZAP_ZONE_REG_NUM = 10'h03B0;
	// Reset value of the zone override register: every zone is 00.
	localparam logic [31:0] ZAP_ZONE_REG_RST = 32'h0000_0000;
	// Field geometry.
	localparam int ZAP_ZONE_CNT = 16;
	localparam int ZAP_ZONE_W = 2;
	// Zone field encodings.
	localparam logic [1:0] ZAP_Z_NOACC = 2'b00;
	localparam logic [1:0] ZAP_Z_FULL = 2'b11;

	// Kind of access presented for checking.
	typedef enum logic [4:0] {
		ZAP_OP_LOAD = 5'h00,
		ZAP_OP_STORE = 5'h01,
		ZAP_OP_FETCH = 5'h02,
		ZAP_OP_DCBZ = 5'h03,
		ZAP_OP_DCBI = 5'h04,
		ZAP_OP_DCCCI = 5'h05,
		ZAP_OP_ICCCI = 5'h06,
		ZAP_OP_DCBF = 5'h07,
		ZAP_OP_DCBST = 5'h08,
		ZAP_OP_DCBA = 5'h09,
		ZAP_OP_DCBT = 5'h0A,
		ZAP_OP_DCBTST = 5'h0B,
		ZAP_OP_ICBT = 5'h0C,
		ZAP_OP_DCREAD = 5'h0D,
		ZAP_OP_ICBI = 5'h0E,
		ZAP_OP_ICREAD = 5'h0F
	} zap_op_t;

	// Fields of the matched translation entry used by the check.
	typedef struct packed {
		logic entry_ok;
		logic store_permit;
		logic run_permit;
		logic [3:0] zone_select;
	} zap_entry_t;

	// One access request.
	typedef struct packed {
		logic valid;
		zap_op_t op;
		logic user_flag;
		logic relocate;
		logic executing;
		zap_entry_t entry;
	} zap_req_t;

	// Check result, one cycle after the request.
	typedef struct packed {
		logic done;
		logic allow;
		logic data_storage_int;
		logic instr_storage_int;
		logic nop;
	} zap_resp_t;
endpackage

// File: rtl/zap_zone_sel.sv
`timescale 1ns/10ps
// Picks one zone field; zone 0 sits in the top bit pair.
module zap_zone_sel import zap_pkg::*; (
	// Register and select.
	input wire logic [31:0] zone_reg,
	input wire logic [3:0] zone_select,
	// Selected field.
	output logic [1:0] zone_field
);
	// Big-endian numbering: zone n occupies little-endian bits 31-2n and 30-2n.
	wire [4:0] shift_amt = 5'(5'd30 - {zone_select, 1'b0});
	wire [31:0] shifted = zone_reg >> shift_amt;
	assign zone_field = shifted[1:0];
endmodule

// File: rtl/zap_perm.sv
`timescale 1ns/10ps
// Effective permissions after the zone override.
module zap_perm import zap_pkg::*; (
	// Inputs.
	input wire logic [1:0] zone_field,
	input wire logic user_flag,
	input wire zap_entry_t entry,
	// Effective permissions.
	output logic read_ok,
	output logic write_ok,
	output logic exec_ok
);
	// User mode: 00 denies, 11 forces; privileged: 1x forces, 00 never denies.
	wire deny = user_flag && (zone_field == ZAP_Z_NOACC);
	wire force_rw = user_flag ? (zone_field == ZAP_Z_FULL) : zone_field[1];
	// Without an override the entry flags decide.
	assign read_ok = entry.entry_ok && !deny;
	assign write_ok = read_ok && (force_rw || entry.store_permit);
	assign exec_ok = read_ok && (force_rw || entry.run_permit);
endmodule

// File: rtl/zap_top.sv
`timescale 1ns/10ps
// Operation
// - 32-bit register of sixteen 2-bit zones
// - Zone select indexes one zone field
// - User mode zone 00 denies all but invalidates, array reads
// - User zone 01/10 uses entry flags
// - User zone 11 forces write and execute
// - Privileged zone 00/01 uses entry flags
// - Privileged zone 10/11 forces write, execute
// - Privileged register 944 via move instructions
// - Zone write affects all member pages
// - Cache ops checked as data, DSI only
// - Block zero: store check plus user zone
// - Block invalidate: store permit only
// - Class invalidate: store permit only
// - Icache class invalidate ignores store permit
// - Class invalidates may miss; avoid relocation
// - Flush and store-back checked as loads
// - Touch and allocate failures become no-ops
// - Array reads, icache invalidate never violate
// - Zone 00 denies only in user mode
// - No checks while translation is off
// - Fetch fault raised at execute only
module zap_top import zap_pkg::*; (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Special-purpose register move port.
	input wire logic spr_wr,
	input wire logic spr_rd,
	input wire logic [9:0] spr_num,
	input wire logic spr_user,
	input wire logic [31:0] spr_wdata,
	output logic [31:0] spr_rdata,
	output logic spr_ack,
	output logic spr_priv_fault,
	// Access check.
	input wire zap_req_t req,
	output zap_resp_t resp
);
	// Zone override register and its next value.
	logic [31:0] zone_reg_ff;
	logic [31:0] nxt_zone_reg;
	// Registered outputs of the move port.
	logic [31:0] spr_rdata_ff;
	logic spr_ack_ff;
	logic spr_priv_fault_ff;
	// Registered check result.
	zap_resp_t resp_ff;
	zap_resp_t nxt_resp;

	// Decode of the move port; only a privileged move to 944 touches the register.
	wire spr_hit = (spr_num == ZAP_ZONE_REG_NUM);
	wire spr_any = (spr_wr || spr_rd) && spr_hit;
	wire spr_bad = spr_any && spr_user;
	wire spr_we = spr_wr && spr_hit && !spr_user;
	wire spr_re = spr_rd && spr_hit && !spr_user;
	// A write replaces the fields at once, so every page selecting them follows
	// without any translation entry being touched.
	assign nxt_zone_reg = spr_we ? spr_wdata : zone_reg_ff;

	// The zone field selected by the matched entry.
	logic [1:0] zone_field;
	zap_zone_sel u_sel (
		.zone_reg(zone_reg_ff),
		.zone_select(req.entry.zone_select),
		.zone_field(zone_field)
	);

	// Effective permissions after the override.
	logic read_ok;
	logic write_ok;
	logic exec_ok;
	zap_perm u_perm (
		.zone_field(zone_field),
		.user_flag(req.user_flag),
		.entry(req.entry),
		.read_ok(read_ok),
		.write_ok(write_ok),
		.exec_ok(exec_ok)
	);

	// User no-access zone, the only zone denial; privileged code never sees it.
	wire zone_deny = req.user_flag && (zone_field == ZAP_Z_NOACC);
	// Write-permission fault after override; the zone denial is folded in through write_ok.
	wire store_denied = !write_ok;
	// Missing entry validity is treated as a denial for ordinary accesses.
	wire load_denied = !read_ok;

	// Class of each operation.
	logic is_store_class;
	logic is_load_class;
	logic is_touch;
	logic is_alloc;
	logic is_priv_free;
	logic is_wp_only;
	logic is_fetch;
	// Operation classification; kept combinational so a new op costs one line.
	always_comb begin
		is_store_class = 1'b0;
		is_load_class = 1'b0;
		is_touch = 1'b0;
		is_alloc = 1'b0;
		is_priv_free = 1'b0;
		is_wp_only = 1'b0;
		is_fetch = 1'b0;
		case (req.op)
			ZAP_OP_STORE, ZAP_OP_DCBZ: begin
				is_store_class = 1'b1;
			end
			ZAP_OP_LOAD, ZAP_OP_DCBF, ZAP_OP_DCBST: begin
				is_load_class = 1'b1;
			end
			ZAP_OP_DCBI, ZAP_OP_DCCCI: begin
				// A class invalidate may still miss in the lookup ahead of this block.
				is_wp_only = 1'b1;
			end
			ZAP_OP_ICCCI, ZAP_OP_DCREAD, ZAP_OP_ICBI, ZAP_OP_ICREAD: begin
				is_priv_free = 1'b1;
			end
			ZAP_OP_DCBA: begin
				is_alloc = 1'b1;
			end
			ZAP_OP_DCBT, ZAP_OP_DCBTST, ZAP_OP_ICBT: begin
				is_touch = 1'b1;
			end
			ZAP_OP_FETCH: begin
				is_fetch = 1'b1;
			end
			default: begin
				is_priv_free = 1'b1;
			end
		endcase
	end

	// Per-class fault terms.
	wire f_store = store_denied;
	wire f_load = load_denied;
	// Write-protect-only ops ignore the zone denial, so only the entry's write flag
	// after override matters.
	wire wp_ok = req.entry.store_permit || (req.user_flag ? (zone_field == ZAP_Z_FULL) :
		zone_field[1]);
	wire f_wp = !wp_ok;
	wire f_alloc = store_denied;
	wire f_touch = zone_deny;
	// A fetch fault only counts when the instruction actually executes.
	wire f_fetch = !exec_ok && req.executing;

	// Result of the check; cache ops fault only to the data side.
	always_comb begin
		nxt_resp = '0;
		nxt_resp.done = req.valid;
		nxt_resp.allow = req.valid;
		if (req.valid && req.relocate) begin
			if (is_store_class && f_store) begin
				nxt_resp.data_storage_int = 1'b1;
				nxt_resp.allow = 1'b0;
			end else if (is_load_class && f_load) begin
				nxt_resp.data_storage_int = 1'b1;
				nxt_resp.allow = 1'b0;
			end else if (is_wp_only && f_wp) begin
				nxt_resp.data_storage_int = 1'b1;
				nxt_resp.allow = 1'b0;
			end else if ((is_alloc && f_alloc) || (is_touch && f_touch)) begin
				nxt_resp.nop = 1'b1;
				nxt_resp.allow = 1'b0;
			end else if (is_fetch && f_fetch) begin
				nxt_resp.instr_storage_int = 1'b1;
				nxt_resp.allow = 1'b0;
			end else if (is_fetch && !req.executing) begin
				nxt_resp.allow = exec_ok;
			end
		end
		// Real mode: every access passes unchecked.
		if (!req.relocate) begin
			nxt_resp.allow = req.valid;
		end
	end

	// Zone register; all zeros after reset.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			zone_reg_ff <= ZAP_ZONE_REG_RST;
		end else begin
			zone_reg_ff <= nxt_zone_reg;
		end
	end

	// Move port answer, one cycle after the request.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			spr_rdata_ff <= '0;
			spr_ack_ff <= 1'b0;
			spr_priv_fault_ff <= 1'b0;
		end else begin
			spr_rdata_ff <= spr_re ? zone_reg_ff : '0;
			spr_ack_ff <= spr_any && !spr_user;
			spr_priv_fault_ff <= spr_bad;
		end
	end

	// Check result register.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			resp_ff <= '0;
		end else begin
			resp_ff <= nxt_resp;
		end
	end

	assign spr_rdata = spr_rdata_ff;
	assign spr_ack = spr_ack_ff;
	assign spr_priv_fault = spr_priv_fault_ff;
	assign resp = resp_ff;
endmodule

// File: verification/zap_top_assertions.sv
`timescale 1ns/10ps
// Port-level checks of the zone protection block.
module zap_top_assertions import zap_pkg::*; (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Register move port.
	input wire logic spr_wr,
	input wire logic spr_rd,
	input wire logic [9:0] spr_num,
	input wire logic spr_user,
	input wire logic [31:0] spr_wdata,
	input wire logic [31:0] spr_rdata,
	input wire logic spr_ack,
	input wire logic spr_priv_fault,
	// Access check.
	input wire zap_req_t req,
	input wire zap_resp_t resp
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// A move that names the zone register.
	logic hit;
	assign hit = (spr_wr || spr_rd) && spr_num == ZAP_ZONE_REG_NUM;
	// Privileged write and read steps.
	sequence s_wr;
		spr_wr && hit && !spr_user;
	endsequence
	sequence s_rd;
		spr_rd && hit && !spr_user;
	endsequence
	AST_WR_RD: assert property (s_wr ##1 s_rd |=> spr_rdata == $past(spr_wdata, 2))
		else $error("read misses last write");
	AST_USER: assert property (hit && spr_user |=> spr_priv_fault && !spr_ack && !spr_rdata)
		else $error("user move not refused");
	AST_PRIV: assert property (hit && !spr_user |=> spr_ack && !spr_priv_fault)
		else $error("privileged move not taken");
	AST_REAL: assert property (req.valid && !req.relocate |=> resp.done && resp.allow)
		else $error("real mode access checked");
	AST_NO_ISI: assert property (req.valid && req.op != ZAP_OP_FETCH |=> !resp.instr_storage_int)
		else $error("cache op raised fetch fault");
	AST_SPEC: assert property (req.valid && !req.executing |=> !resp.instr_storage_int)
		else $error("unexecuted fetch faulted");
	AST_PLOAD: assert property (req.valid && req.op inside {ZAP_OP_DCREAD, ZAP_OP_ICBI,
		ZAP_OP_ICREAD} |=> resp.allow && !resp.data_storage_int)
		else $error("privileged load denied");
	AST_TOUCH: assert property (req.valid && req.op inside {ZAP_OP_DCBA, ZAP_OP_DCBT,
		ZAP_OP_DCBTST, ZAP_OP_ICBT} |=> !resp.data_storage_int)
		else $error("touch raised data fault");
	AST_PZONE: assert property (req.valid && !req.user_flag && req.op inside {ZAP_OP_DCBF,
		ZAP_OP_DCBST} |=> !resp.data_storage_int)
		else $error("privileged flush denied");
endmodule
bind zap_top zap_top_assertions chk (.clk, .rst, .spr_wr, .spr_rd, .spr_num, .spr_user,
	.spr_wdata, .spr_rdata, .spr_ack, .spr_priv_fault, .req, .resp);

// File: verification/zap_tlb_model.sv
`timescale 1ns/10ps
// Lookup stand-in: fills in the matched entry for the page the pipeline names.
module zap_tlb_model import zap_pkg::*; (
	// Access from the pipeline; its entry part is ignored.
	input wire zap_req_t issue,
	input wire logic [1:0] page,
	// Access with the matched entry.
	output zap_req_t req
);
	// Four entries, so unrelated pages can share one zone.
	zap_entry_t tbl [4];
	assign req = '{issue.valid, issue.op, issue.user_flag, issue.relocate,
		issue.executing, tbl[page]};
endmodule

// File: verification/zone_access_protection_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module zone_access_protection_bench import zap_pkg::*;;
	// Bench state; the seed is fixed so runs repeat.
	logic clk = 0, rst = 1, spr_wr = 0, spr_rd = 0, spr_user = 0, spr_ack, spr_priv_fault;
	logic [9:0] spr_num = '0;
	logic [31:0] spr_wdata = '0, spr_rdata, zreg = '0, zv, r, seed = 32'h5106;
	logic [1:0] page = '0;
	zap_req_t issue = '0, req;
	zap_resp_t resp;
	zap_entry_t e;
	zap_op_t op;
	int n_fail = 0, checked = 0;
	always #20 clk = ~clk;
	zap_tlb_model tlb (.issue, .page, .req);
	zap_top dut (.clk, .rst, .spr_wr, .spr_rd, .spr_num, .spr_user, .spr_wdata,
		.spr_rdata, .spr_ack, .spr_priv_fault, .req, .resp);
	// Random source.
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected answer worked out from the zone field and the entry flags.
	function automatic zap_resp_t exp_resp(zap_op_t o, logic u, logic rl, logic x,
		zap_entry_t t, logic [31:0] z);
		logic [1:0] f;
		logic na, fo, v;
		f = z[31-2*t.zone_select -: 2];
		na = u && f == 2'b00;
		fo = u ? f == 2'b11 : f[1];
		case (o)
			ZAP_OP_LOAD: v = na || !t.entry_ok;
			ZAP_OP_STORE: v = na || !t.entry_ok || !(fo || t.store_permit);
			ZAP_OP_FETCH: v = na || !(fo || t.run_permit);
			ZAP_OP_DCBZ, ZAP_OP_DCBA: v = na || !(fo || t.store_permit);
			ZAP_OP_DCBI, ZAP_OP_DCCCI: v = !(fo || t.store_permit);
			ZAP_OP_DCBF, ZAP_OP_DCBST, ZAP_OP_DCBT, ZAP_OP_DCBTST, ZAP_OP_ICBT: v = na;
			default: v = 0;
		endcase
		v = v && rl;
		if (o inside {ZAP_OP_DCBA, ZAP_OP_DCBT, ZAP_OP_DCBTST, ZAP_OP_ICBT})
			return '{1'b1, !v, 1'b0, 1'b0, v};
		if (o == ZAP_OP_FETCH)
			return '{1'b1, !v, 1'b0, v && x, 1'b0};
		return '{1'b1, !v, v, 1'b0, 1'b0};
	endfunction
	// One register move; answers stand for one cycle after the move.
	task automatic special_purpose_register(input logic wr, input logic u, input logic [9:0] n, input logic [31:0] d);
		logic ok;
		ok = n == ZAP_ZONE_REG_NUM;
		@(posedge clk);
		spr_wr <= wr;
		spr_rd <= !wr;
		spr_user <= u;
		spr_num <= n;
		spr_wdata <= d;
		@(posedge clk);
		spr_wr <= 0;
		spr_rd <= 0;
		#1;
		`CHK("spr_ack", ok && !u, spr_ack)
		`CHK("spr_priv_fault", ok && u, spr_priv_fault)
		if (!wr)
			`CHK("spr_rdata", (ok && !u) ? zreg : 32'h0000_0000, spr_rdata)
		if (wr && ok && !u)
			zreg = d;
	endtask
	// One checked access; the answer comes one cycle later.
	task automatic acc(input zap_op_t o, input logic u, input logic [1:0] pg, input logic rl,
		input logic x);
		@(posedge clk);
		issue <= '{1'b1, o, u, rl, x, zap_entry_t'(0)};
		page <= pg;
		@(posedge clk);
		issue.valid <= 0;
		#1;
		`CHK("resp", exp_resp(o, u, rl, x, tlb.tbl[pg], zreg), resp)
	endtask
	// Verdict and end of run.
	task automatic end_sim();
		if (n_fail == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 4; i++)
			tlb.tbl[i] = '{1'b1, 1'b1, 1'b1, 4'h0};
		repeat (20) @(posedge clk);
		rst <= 0;
		special_purpose_register(0, 0, ZAP_ZONE_REG_NUM, 0);
		acc(ZAP_OP_LOAD, 1, 0, 1, 0);
		acc(ZAP_OP_LOAD, 0, 0, 1, 0);
		special_purpose_register(1, 1, ZAP_ZONE_REG_NUM, 32'hFFFF_FFFF);
		special_purpose_register(1, 0, 10'h03B1, 32'hFFFF_FFFF);
		special_purpose_register(0, 1, ZAP_ZONE_REG_NUM, 0);
		// Every code in every zone, with the other zones holding the opposite code.
		for (int z = 0; z < 16; z++) begin
			for (int c = 0; c < 4; c++) begin
				zv = {16{~c[1:0]}};
				zv[31-2*z -: 2] = c[1:0];
				@(posedge clk);
				spr_wr <= 1;
				spr_user <= 0;
				spr_num <= ZAP_ZONE_REG_NUM;
				spr_wdata <= zv;
				zreg = zv;
				special_purpose_register(0, 0, ZAP_ZONE_REG_NUM, 0);
				tlb.tbl[0] = '{1'b1, 1'b0, 1'b0, 4'(z)};
				tlb.tbl[3] = tlb.tbl[0];
				acc(ZAP_OP_STORE, 1, 0, 1, 0);
				acc(ZAP_OP_STORE, 0, 3, 1, 0);
				acc(ZAP_OP_FETCH, 1, 3, 1, 1);
			end
		end
		// Random mix; class invalidates are kept out of translated mode.
		for (int i = 0; i < 400; i++) begin
			r = xs();
			op = zap_op_t'(r[3:0]);
			e = r[15:9];
			if (!(op inside {ZAP_OP_LOAD, ZAP_OP_STORE}))
				e.entry_ok = 1;
			tlb.tbl[r[17:16]] = e;
			if (r[20:18] == 0)
				special_purpose_register(r[21], r[22], r[23] ? ZAP_ZONE_REG_NUM : 10'h0155, xs());
			acc(op, r[4], r[17:16], r[7:5] != 0 && !(op inside {ZAP_OP_DCCCI, ZAP_OP_ICCCI}),
				r[8]);
		end
		end_sim();
	end
	// A run that hangs is cut short and counted as broken.
	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		end_sim();
	end
endmodule
